//--- hdl/jesd_lane_ovr_config_regs.sv
module jesd_lane_ovr_config_regs
  import overrange_config_pkg::*;
#(
  parameter int unsigned CMD_W = SYNC_CMD_W,
  parameter int unsigned CNT_W = HOLD_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  cfg_link_if.device link,
  input wire logic [7:0] link_mode_lanes_b,
  input wire logic link_mode_64b66b,
  input wire logic [3:0] test_pattern_select,
  input wire logic [1:0] channel_power_down,
  input wire logic [7:0] sample_a,
  input wire logic [7:0] sample_b,
  output logic [7:0] lane_clock_enable_b,
  output logic [7:0] serializer_enable_b,
  output logic [7:0][3:0] lane_pattern_b,
  output logic sync_word_crc,
  output logic sync_word_fec,
  output logic [CMD_W-1:0] sync_header_command,
  output logic [3:0] overrange_link_bits
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] link_b_extra_lane_enable;
    logic [7:0] sync_word_mode;
    logic [7:0] overrange_threshold_zero;
    logic [7:0] overrange_threshold_one;
    logic [7:0] overrange_config;
    logic [7:0] cfg_rdata;
    logic cfg_ready;
    logic [7:0] lane_clock_en;
    logic [7:0] ser_en;
    logic [7:0][3:0] lane_pattern;
    logic sync_crc;
    logic sync_fec;
    logic [CMD_W-1:0] sync_cmd;
    logic [3:0] ovr_flags;
  } dev_state_s;

  localparam dev_state_s DEV_RESET = '{
    link_b_extra_lane_enable: LINK_B_EXTRA_RST,
    sync_word_mode: SYNC_WORD_RST,
    overrange_threshold_zero: THR_ZERO_RST,
    overrange_threshold_one: THR_ONE_RST,
    overrange_config: OVERRANGE_CONFIG_RST,
    default: '0
  };

  dev_state_s cur;
  dev_state_s next_state;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // magnitude of a two's complement sample, 9 bits so -128 gives 128
  function automatic logic [8:0] magnitude(input logic [7:0] s);
    logic [8:0] ext;
    ext = {s[7], s};
    magnitude = s[7] ? (9'h000 - ext) : ext;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [7:0] extra_only;
    logic [7:0] clk_want;
    logic [7:0] ser_want;
    logic lower_ok;
    logic link_b_up;
    logic spare_ser;
    logic [1:0] sync_sel;
    logic [8:0] mag_a;
    logic [8:0] mag_b;
    logic [8:0] thr0;
    logic [8:0] thr1;

    extra_only = '0;
    clk_want = '0;
    ser_want = '0;
    lower_ok = 1'b1;
    link_b_up = 1'b0;
    spare_ser = 1'b0;
    sync_sel = 2'h0;
    mag_a = 9'h000;
    mag_b = 9'h000;
    thr0 = 9'h000;
    thr1 = 9'h000;
    next_state = cur;

    // register access over the configuration port
    next_state.cfg_ready = 1'b0;
    if (link.cfg_sel) begin
      next_state.cfg_ready = 1'b1;
      next_state.cfg_rdata = 8'h00;
      case (link.cfg_addr)
        LINK_B_EXTRA_OFS: begin
          next_state.cfg_rdata = cur.link_b_extra_lane_enable;
          if (link.cfg_write) begin
            next_state.link_b_extra_lane_enable = link.cfg_wdata;
          end
        end
        SYNC_WORD_OFS: begin
          next_state.cfg_rdata = cur.sync_word_mode;
          if (link.cfg_write) begin
            next_state.sync_word_mode = link.cfg_wdata;
          end
        end
        THR_ZERO_OFS: begin
          next_state.cfg_rdata = cur.overrange_threshold_zero;
          if (link.cfg_write) begin
            next_state.overrange_threshold_zero = link.cfg_wdata; // see R14
          end
        end
        THR_ONE_OFS: begin
          next_state.cfg_rdata = cur.overrange_threshold_one;
          if (link.cfg_write) begin
            next_state.overrange_threshold_one = link.cfg_wdata; // see R15
          end
        end
        OVERRANGE_CONFIG_OFS: begin
          next_state.cfg_rdata = cur.overrange_config;
          if (link.cfg_write) begin
            next_state.overrange_config = link.cfg_wdata;
          end
        end
        default: begin
          next_state.cfg_rdata = 8'h00;
        end
      endcase
    end

    // lane enables for link B; lane 0 comes from the mode only
    link_b_up = ~channel_power_down[1];
    spare_ser = cur.link_b_extra_lane_enable[SPARE_SER_BIT];
    for (int n = 0; n < LINK_B_LANES; n++) begin
      logic extra;
      extra = (n != 0) && cur.link_b_extra_lane_enable[n]; // see R1
      extra_only[n] = extra & ~link_mode_lanes_b[n];
      // clocks follow any enable; extra-lane serializers only with the spare control
      clk_want[n] = link_b_up & (link_mode_lanes_b[n] | extra); // see R2, R8
      ser_want[n] = link_b_up & (link_mode_lanes_b[n] | (extra & spare_ser)); // see R3, R4, R8
    end

    // a serializer is enabled only if every lower lane is clocked
    for (int n = 0; n < LINK_B_LANES; n++) begin
      next_state.lane_clock_en[n] = clk_want[n];
      next_state.ser_en[n] = ser_want[n] & lower_ok; // see R9
      lower_ok = lower_ok & clk_want[n];
    end

    // per-lane pattern: mode and test pattern, ramp for extra-only lanes on pattern 0 or 5
    for (int n = 0; n < LINK_B_LANES; n++) begin
      next_state.lane_pattern[n] = test_pattern_select; // see R6
      if (extra_only[n] &&
          (test_pattern_select == PATTERN_OFF || test_pattern_select == PATTERN_FIVE)) begin
        next_state.lane_pattern[n] = PATTERN_RAMP; // see R7
      end
    end

    // sync word content; reserved codes select neither
    sync_sel = cur.sync_word_mode[SYNC_MODE_LSB +: 2];
    next_state.sync_crc = link_mode_64b66b & (sync_sel == SYNC_CRC12); // see R10, R11
    next_state.sync_fec = link_mode_64b66b & (sync_sel == SYNC_FEC); // see R10, R11
    // no command channel: headers always idle
    next_state.sync_cmd = '0; // see R12

    // over-range detection, inclusive compare
    mag_a = magnitude(sample_a);
    mag_b = magnitude(sample_b);
    thr0 = {1'b0, cur.overrange_threshold_zero};
    thr1 = {1'b0, cur.overrange_threshold_one};
    next_state.ovr_flags[0] = mag_a >= thr0; // see R14, R18
    next_state.ovr_flags[1] = mag_a >= thr1; // see R15, R18
    next_state.ovr_flags[2] = mag_b >= thr0; // see R14, R18
    next_state.ovr_flags[3] = mag_b >= thr1; // see R15, R18
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= DEV_RESET;
    end else begin
      cur <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // over-range pins, stretched; link bits bypass the pin enable

  logic [3:0] pins;

  for (genvar i = 0; i < 4; i++) begin : g_pin
    ovr_pulse_stretch #(
      .CNT_W(CNT_W)
    ) u_stretch (
      .hclk(hclk),
      .hresetn(hresetn),
      .trigger(cur.ovr_flags[i]),
      .pin_enable(cur.overrange_config[OVR_PIN_EN_BIT]), // see R16
      .hold_exponent(cur.overrange_config[OVR_HOLD_LSB +: 3]), // see R17
      .pin(pins[i])
    );
  end

  assign link.overrange_pin_a_zero = pins[0];
  assign link.overrange_pin_a_one = pins[1];
  assign link.overrange_pin_b_zero = pins[2];
  assign link.overrange_pin_b_one = pins[3];

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.cfg_rdata = cur.cfg_rdata;
  assign link.cfg_ready = cur.cfg_ready;
  assign lane_clock_enable_b = cur.lane_clock_en;
  assign serializer_enable_b = cur.ser_en;
  assign lane_pattern_b = cur.lane_pattern;
  assign sync_word_crc = cur.sync_crc;
  assign sync_word_fec = cur.sync_fec;
  assign sync_header_command = cur.sync_cmd;
  // link bits stay live even with the pins disabled
  assign overrange_link_bits = cur.ovr_flags; // see R16

endmodule

//--- common/overrange_config_pkg.sv
// Notes on behaviour
// R1 - lane bits 7:1 enable link B lanes 1-7
// R2 - extra lane bit turns on link-layer clock
// R3 - spare serializer off: only clocks enabled
// R4 - spare serializer on: serializers and clocks
// R5 - change lane register only while link disabled
// R6 - extra lanes follow mode and test pattern
// R7 - extra-only lane sends ramp for pattern 0/5
// R8 - powered-down link stays off despite extra lanes
// R9 - serializer n needs lanes 0..n-1 enabled
// R10 - sync word: 0 CRC-12, 2 FEC, others reserved
// R11 - sync word choice only in 64b/66b modes
// R12 - all sync header command fields are zero
// R13 - change sync word only while link disabled
// R14 - threshold zero, reset F2, sets flag 0
// R15 - threshold one, reset AB, sets flag 1
// R16 - pin enable gates pins, not link bits
// R17 - pin pulse lasts 8 times 2^N cycles
// R18 - flag when magnitude at or above threshold
package overrange_config_pkg;

  localparam int unsigned CFG_ADDR_W = 10;
  localparam int unsigned LINK_B_LANES = 8;
  localparam int unsigned SYNC_CMD_W = 8;
  localparam int unsigned HOLD_CNT_W = 11;

  // device register offsets and reset values
  localparam logic [9:0] LINK_B_EXTRA_OFS = 10'h20B;
  localparam logic [9:0] SYNC_WORD_OFS = 10'h20F;
  localparam logic [9:0] THR_ZERO_OFS = 10'h211;
  localparam logic [9:0] THR_ONE_OFS = 10'h212;
  localparam logic [9:0] OVERRANGE_CONFIG_OFS = 10'h213;
  localparam logic [7:0] LINK_B_EXTRA_RST = 8'h00;
  localparam logic [7:0] SYNC_WORD_RST = 8'h00;
  localparam logic [7:0] THR_ZERO_RST = 8'hF2;
  localparam logic [7:0] THR_ONE_RST = 8'hAB;
  localparam logic [7:0] OVERRANGE_CONFIG_RST = 8'h07;

  // field positions
  localparam int unsigned SPARE_SER_BIT = 0;
  localparam int unsigned SYNC_MODE_LSB = 0;
  localparam int unsigned OVR_PIN_EN_BIT = 3;
  localparam int unsigned OVR_HOLD_LSB = 0;

  localparam logic [1:0] SYNC_CRC12 = 2'h0;
  localparam logic [1:0] SYNC_FEC = 2'h2;
  localparam logic [3:0] PATTERN_OFF = 4'h0;
  localparam logic [3:0] PATTERN_RAMP = 4'h4;
  localparam logic [3:0] PATTERN_FIVE = 4'h5;

  // pin pulse base length in device clock cycles
  localparam int unsigned OVR_HOLD_BASE = 8;

  // controller registers on the AHB-Lite side
  localparam logic [7:0] CTRL_CMD_OFS = 8'h00;
  localparam logic [7:0] CTRL_WDATA_OFS = 8'h04;
  localparam logic [7:0] CTRL_GO_OFS = 8'h08;
  localparam logic [7:0] CTRL_RDATA_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
  localparam int unsigned CMD_WRITE_BIT = 16;
  localparam int unsigned IRQ_W = 6;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_PIN_LSB = 1;
  localparam int unsigned IRQ_REFUSED_BIT = 5;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

//--- common/cfg_link_if.sv
interface cfg_link_if;
  import overrange_config_pkg::*;

  logic cfg_sel;
  logic cfg_write;
  logic [CFG_ADDR_W-1:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic cfg_ready;
  logic overrange_pin_a_zero;
  logic overrange_pin_a_one;
  logic overrange_pin_b_zero;
  logic overrange_pin_b_one;

  modport device (
    input cfg_sel, cfg_write, cfg_addr, cfg_wdata,
    output cfg_rdata, cfg_ready,
    output overrange_pin_a_zero, overrange_pin_a_one,
    output overrange_pin_b_zero, overrange_pin_b_one
  );

  modport controller (
    output cfg_sel, cfg_write, cfg_addr, cfg_wdata,
    input cfg_rdata, cfg_ready,
    input overrange_pin_a_zero, overrange_pin_a_one,
    input overrange_pin_b_zero, overrange_pin_b_one
  );
endinterface

//--- hdl/ovr_pulse_stretch.sv
module ovr_pulse_stretch
  import overrange_config_pkg::*;
#(
  parameter int unsigned CNT_W = HOLD_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic trigger,
  input wire logic pin_enable,
  input wire logic [2:0] hold_exponent,
  output logic pin
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic pin;
  } stretch_s;

  stretch_s cur;
  stretch_s nxt;

  always_comb begin
    logic [CNT_W-1:0] hold;
    hold = CNT_W'(OVR_HOLD_BASE) << hold_exponent; // see R17
    nxt = cur;
    // a new trigger restarts the window, so bursts merge
    if (trigger) begin
      nxt.count = hold - CNT_W'(1);
    end else if (cur.count != '0) begin
      nxt.count = cur.count - CNT_W'(1);
    end
    nxt.pin = pin_enable & (trigger | (cur.count != '0)); // see R16
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign pin = cur.pin;

endmodule

//--- hdl/cfg_link_controller.sv
module cfg_link_controller
  import overrange_config_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic transmit_link_enable,
  cfg_link_if.controller link
);

  typedef enum logic {ST_IDLE, ST_WAIT} ctrl_state_e;

  typedef struct packed {
    ctrl_state_e state;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] ap_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [CFG_ADDR_W-1:0] cmd_addr;
    logic cmd_write;
    logic [7:0] cmd_wdata;
    logic [7:0] rdata;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [3:0] pins_q;
    logic cfg_sel;
  } ctrl_state_s;

  localparam ctrl_state_s CTRL_RESET = '{state: ST_IDLE, hreadyout: 1'b1, default: '0};

  ctrl_state_s cur;
  ctrl_state_s next_state;
  logic [3:0] pins;

  assign pins = {link.overrange_pin_b_one, link.overrange_pin_b_zero,
                 link.overrange_pin_a_one, link.overrange_pin_a_zero};

  always_comb begin
    logic [IRQ_W-1:0] set_bits;
    logic go;
    logic guarded;
    set_bits = '0;
    go = 1'b0;
    guarded = 1'b0;
    next_state = cur;
    next_state.wr_pend = 1'b0;
    next_state.cfg_sel = 1'b0;

    // write data phase
    if (cur.wr_pend) begin
      case (cur.ap_addr)
        CTRL_CMD_OFS: begin
          next_state.cmd_addr = hwdata[CFG_ADDR_W-1:0];
          next_state.cmd_write = hwdata[CMD_WRITE_BIT];
        end
        CTRL_WDATA_OFS: next_state.cmd_wdata = hwdata[7:0];
        CTRL_GO_OFS: go = hwdata[0];
        IRQ_STATUS_OFS: next_state.irq_status = cur.irq_status & ~hwdata[IRQ_W-1:0];
        IRQ_MASK_OFS: next_state.irq_mask = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // read data phase: one wait state so a preceding write is seen
    if (cur.rd_pend) begin
      next_state.rd_pend = 1'b0;
      next_state.hreadyout = 1'b1;
      case (cur.ap_addr)
        CTRL_CMD_OFS: next_state.hrdata = 32'({cur.cmd_write, 6'h00, cur.cmd_addr});
        CTRL_WDATA_OFS: next_state.hrdata = {24'h000000, cur.cmd_wdata};
        CTRL_GO_OFS: next_state.hrdata = {31'h00000000, cur.state == ST_WAIT};
        CTRL_RDATA_OFS: next_state.hrdata = {24'h000000, cur.rdata};
        IRQ_STATUS_OFS: next_state.hrdata = 32'(cur.irq_status);
        IRQ_MASK_OFS: next_state.hrdata = 32'(cur.irq_mask);
        default: next_state.hrdata = 32'h00000000;
      endcase
    end

    // address phase
    if (hsel && htrans[1] && hready && hsize == HSIZE_WORD) begin
      next_state.ap_addr = haddr[7:0];
      if (hwrite) begin
        next_state.wr_pend = 1'b1;
      end else begin
        next_state.rd_pend = 1'b1;
        next_state.hreadyout = 1'b0;
      end
    end

    // device access sequencer
    guarded = cur.cmd_write &&
              (cur.cmd_addr == LINK_B_EXTRA_OFS || cur.cmd_addr == SYNC_WORD_OFS);
    case (cur.state)
      ST_IDLE: begin
        if (go) begin
          // lane and sync word settings are locked while the link runs
          if (guarded && transmit_link_enable) begin
            set_bits[IRQ_REFUSED_BIT] = 1'b1; // see R5, R13
          end else begin
            next_state.cfg_sel = 1'b1;
            next_state.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (link.cfg_ready) begin
          next_state.rdata = link.cfg_rdata;
          set_bits[IRQ_DONE_BIT] = 1'b1;
          next_state.state = ST_IDLE;
        end
      end
      default: next_state.state = ST_IDLE;
    endcase

    // rising pin edges; a set beats a clear in the same cycle
    next_state.pins_q = pins;
    set_bits[IRQ_PIN_LSB +: 4] = pins & ~cur.pins_q;
    next_state.irq_status = next_state.irq_status | set_bits;
    next_state.irq = |(next_state.irq_status & next_state.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= CTRL_RESET;
    end else begin
      cur <= next_state;
    end
  end

  assign hreadyout = cur.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = cur.hrdata;
  assign irq = cur.irq;
  assign link.cfg_sel = cur.cfg_sel;
  assign link.cfg_write = cur.cmd_write;
  assign link.cfg_addr = cur.cmd_addr;
  assign link.cfg_wdata = cur.cmd_wdata;

endmodule

//--- sim/cfg_link_asserts.sv
module cfg_link_asserts
  import overrange_config_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cfg_sel,
  input wire logic cfg_write,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_ready,
  input wire logic overrange_pin_a_zero,
  input wire logic overrange_pin_a_one,
  input wire logic overrange_pin_b_zero,
  input wire logic overrange_pin_b_one
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  // shadow copy of the device registers, fed from the link
  logic [7:0] lane_r, sync_r, thr0_r, thr1_r, ocfg_r, rd_now, exp_q;
  logic [15:0] hi_cnt;
  logic pins;
  assign pins = overrange_pin_a_zero | overrange_pin_a_one | overrange_pin_b_zero | overrange_pin_b_one;
  always_comb begin
    case (cfg_addr)
      LINK_B_EXTRA_OFS: rd_now = lane_r;
      SYNC_WORD_OFS: rd_now = sync_r;
      THR_ZERO_OFS: rd_now = thr0_r;
      THR_ONE_OFS: rd_now = thr1_r;
      OVERRANGE_CONFIG_OFS: rd_now = ocfg_r;
      default: rd_now = 8'h00;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lane_r <= LINK_B_EXTRA_RST;
      sync_r <= SYNC_WORD_RST;
      thr0_r <= THR_ZERO_RST;
      thr1_r <= THR_ONE_RST;
      ocfg_r <= OVERRANGE_CONFIG_RST;
      exp_q <= 8'h00;
      hi_cnt <= 16'h0;
    end else begin
      hi_cnt <= overrange_pin_a_zero ? hi_cnt + 16'h1 : 16'h0;
      if (cfg_sel) begin
        exp_q <= rd_now;
        if (cfg_write && cfg_addr == LINK_B_EXTRA_OFS) lane_r <= cfg_wdata;
        if (cfg_write && cfg_addr == SYNC_WORD_OFS) sync_r <= cfg_wdata;
        if (cfg_write && cfg_addr == THR_ZERO_OFS) thr0_r <= cfg_wdata;
        if (cfg_write && cfg_addr == THR_ONE_OFS) thr1_r <= cfg_wdata;
        if (cfg_write && cfg_addr == OVERRANGE_CONFIG_OFS) ocfg_r <= cfg_wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_access;
    cfg_sel ##1 cfg_ready;
  endsequence
  sequence s_gate_off;
    !ocfg_r[OVR_PIN_EN_BIT] ##1 !ocfg_r[OVR_PIN_EN_BIT] ##1 !ocfg_r[OVR_PIN_EN_BIT];
  endsequence
  a_ready_follows_sel: assert property (cfg_sel |-> s_access) else $error("no answer to request");
  a_ready_has_cause: assert property (cfg_ready |-> $past(cfg_sel)) else $error("answer without request");
  a_sel_one_cycle: assert property (cfg_sel |=> !cfg_sel) else $error("request longer than one cycle");
  a_req_held: assert property (cfg_sel |=> $stable(cfg_addr) && $stable(cfg_write)) else $error("request moved");
  a_read_data_match: assert property (cfg_ready |-> cfg_rdata == exp_q) else $error("read data wrong");
  a_pins_gated_low: assert property (s_gate_off |-> !pins) else $error("pin high while gated");
  a_pin_rise_gated: assert property ($rose(pins) |-> ocfg_r[OVR_PIN_EN_BIT]) else $error("pin rose while gated");
  a_pulse_min_len: assert property ($fell(overrange_pin_a_zero) && $past(ocfg_r[OVR_PIN_EN_BIT], 3)
    |-> hi_cnt >= (16'h8 << ocfg_r[2:0])) else $error("pin pulse too short");
endmodule

//--- sim/testbench.sv
module testbench
  import overrange_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, link_mode_64b66b = 1'b0;
  logic transmit_link_enable = 1'b0, hreadyout, hresp, irq, sync_word_crc, sync_word_fec;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
  logic [1:0] htrans = 2'h0, channel_power_down = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [3:0] test_pattern_select = 4'h0, overrange_link_bits;
  logic [7:0] link_mode_lanes_b = 8'h01, sample_a = 8'h00, sample_b = 8'h00, q;
  logic [7:0] lane_clock_enable_b, serializer_enable_b, sync_header_command;
  logic [7:0][3:0] lane_pattern_b;
  logic [9:0] ra [5] = '{LINK_B_EXTRA_OFS, SYNC_WORD_OFS, THR_ZERO_OFS, THR_ONE_OFS, OVERRANGE_CONFIG_OFS};
  logic [7:0] rv [5] = '{LINK_B_EXTRA_RST, SYNC_WORD_RST, THR_ZERO_RST, THR_ONE_RST, OVERRANGE_CONFIG_RST};
  int bad_count = 0, cmp_count = 0;
  always #2 hclk = ~hclk;
  cfg_link_if link();
  jesd_lane_ovr_config_regs jesd_lane_ovr_config_regs_i (.hclk(hclk), .hresetn(hresetn), .link(link),
    .link_mode_lanes_b(link_mode_lanes_b), .link_mode_64b66b(link_mode_64b66b),
    .test_pattern_select(test_pattern_select), .channel_power_down(channel_power_down),
    .sample_a(sample_a), .sample_b(sample_b), .lane_clock_enable_b(lane_clock_enable_b),
    .serializer_enable_b(serializer_enable_b), .lane_pattern_b(lane_pattern_b), .sync_word_crc(sync_word_crc),
    .sync_word_fec(sync_word_fec), .sync_header_command(sync_header_command),
    .overrange_link_bits(overrange_link_bits));
  cfg_link_controller cfg_link_controller_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .transmit_link_enable(transmit_link_enable), .link(link));
  cfg_link_asserts cfg_link_asserts_i (.hclk(hclk), .hresetn(hresetn), .cfg_sel(link.cfg_sel),
    .cfg_write(link.cfg_write), .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata),
    .cfg_rdata(link.cfg_rdata), .cfg_ready(link.cfg_ready), .overrange_pin_a_zero(link.overrange_pin_a_zero),
    .overrange_pin_a_one(link.overrange_pin_a_one), .overrange_pin_b_zero(link.overrange_pin_b_zero),
    .overrange_pin_b_one(link.overrange_pin_b_one));
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // status seen last is kept in st; polling gives up so a refused order still returns
  task dev(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    logic [31:0] r;
    ahb(1'b1, CTRL_CMD_OFS, (32'(w) << CMD_WRITE_BIT) | 32'(a), r);
    ahb(1'b1, CTRL_WDATA_OFS, 32'(d), r);
    ahb(1'b1, CTRL_GO_OFS, 32'h1, r);
    n = 0;
    st = 32'h0;
    while (st[IRQ_DONE_BIT] !== 1'b1 && n < 8) begin
      ahb(1'b0, IRQ_STATUS_OFS, 32'h0, st);
      n++;
    end
    ahb(1'b1, IRQ_STATUS_OFS, st, r);
    ahb(1'b0, CTRL_RDATA_OFS, 32'h0, r);
    q = r[7:0];
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    for (int i = 0; i < 5; i++) begin
      dev(1'b0, ra[i], 8'h00);
      chk(q, rv[i], "reset value");
    end
    dev(1'b0, 10'h300, 8'h00);
    chk(q, 32'h0, "unmapped read");
    chk(hresp, 32'h0, "okay response");
    $display("regs done");
  endtask
  task lane_case(input logic [7:0] v, input logic [7:0] ce, input logic [7:0] se);
    dev(1'b1, LINK_B_EXTRA_OFS, v);
    repeat (2) @(posedge hclk);
    chk(lane_clock_enable_b, ce, "lane clocks");
    chk(serializer_enable_b, se, "serializers");
  endtask
  task t_lanes;
    logic [3:0] p [3] = '{4'h0, 4'h5, 4'h3};
    lane_case(8'h0E, 8'h0F, 8'h01);
    lane_case(8'hA1, 8'hA1, 8'h01);
    lane_case(8'h0F, 8'h0F, 8'h0F);
    // lane 1 now needed by the mode as well, so it keeps the plain pattern
    link_mode_lanes_b <= 8'h03;
    for (int i = 0; i < 3; i++) begin
      test_pattern_select <= p[i];
      repeat (2) @(posedge hclk);
      chk(lane_pattern_b[1], p[i], "mode lane pattern");
      chk(lane_pattern_b[3], (p[i] == 4'h3) ? p[i] : PATTERN_RAMP, "extra lane pattern");
    end
    channel_power_down <= 2'h2;
    repeat (2) @(posedge hclk);
    chk({lane_clock_enable_b, serializer_enable_b}, 32'h0, "powered down");
    channel_power_down <= 2'h0;
    $display("lanes done");
  endtask
  task t_sync;
    link_mode_64b66b <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      dev(1'b1, SYNC_WORD_OFS, 8'(c));
      chk({sync_word_crc, sync_word_fec}, (c == 0) ? 2'h2 : (c == 2) ? 2'h1 : 2'h0, "sync mode");
    end
    dev(1'b1, SYNC_WORD_OFS, 8'(SYNC_FEC));
    link_mode_64b66b <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({sync_word_crc, sync_word_fec}, 32'h0, "8b10b sync");
    chk(sync_header_command, 32'h0, "command field");
    $display("sync done");
  endtask
  task t_refuse;
    transmit_link_enable <= 1'b1;
    dev(1'b1, LINK_B_EXTRA_OFS, 8'h55);
    chk(st[IRQ_REFUSED_BIT], 32'h1, "lane write refused");
    dev(1'b1, SYNC_WORD_OFS, 8'h00);
    chk(st[IRQ_REFUSED_BIT], 32'h1, "sync write refused");
    dev(1'b1, THR_ONE_OFS, 8'h60);
    transmit_link_enable <= 1'b0;
    dev(1'b0, LINK_B_EXTRA_OFS, 8'h00);
    chk(q, 32'h0F, "lane reg kept");
    dev(1'b0, THR_ONE_OFS, 8'h00);
    chk(q, 32'h60, "threshold written");
    $display("refuse done");
  endtask
  task samp(input logic [7:0] a, input logic [7:0] b, input logic [3:0] e);
    sample_a <= a;
    sample_b <= b;
    @(posedge hclk);
    sample_a <= 8'h00;
    sample_b <= 8'h00;
    @(posedge hclk);
    chk(overrange_link_bits, e, "link flags");
  endtask
  // counts high cycles of one pin over a window a little longer than the pulse
  task pulse(input int n);
    int c;
    dev(1'b1, OVERRANGE_CONFIG_OFS, 8'h08 | 8'(n));
    sample_a <= 8'h7F;
    @(posedge hclk);
    sample_a <= 8'h00;
    c = 0;
    for (int i = 0; i < (8 << n) + 8; i++) begin
      @(posedge hclk);
      c += int'(link.overrange_pin_a_zero === 1'b1);
    end
    chk(c >= (8 << n) && c <= (8 << n) + 1, 32'h1, "pulse length");
  endtask
  task t_ovr;
    logic [31:0] r;
    // short hold: windows opened while gated must end before the pin is enabled
    dev(1'b1, OVERRANGE_CONFIG_OFS, 8'h00);
    dev(1'b1, THR_ZERO_OFS, 8'h40);
    samp(8'h40, 8'h3F, 4'h1);
    samp(8'hA0, 8'hC0, 4'h7);
    samp(8'h00, 8'h80, 4'hC);
    chk(link.overrange_pin_a_zero, 32'h0, "pin gated");
    ahb(1'b1, IRQ_MASK_OFS, 32'h2, r);
    pulse(0);
    chk(irq, 32'h1, "irq on pin edge");
    ahb(1'b1, IRQ_STATUS_OFS, 32'h3E, r);
    repeat (2) @(posedge hclk);
    chk(irq, 32'h0, "irq cleared");
    ahb(1'b1, IRQ_MASK_OFS, 32'h0, r);
    pulse(1);
    chk(irq, 32'h0, "irq masked");
    $display("ovr done");
  endtask
  ////////////////////////////////////////////////////////////
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_lanes();
    t_sync();
    t_refuse();
    t_ovr();
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    wrap_up();
  end
endmodule
